// ### src/mcs_core.sv
// Program counter, return stack, data RAM, accumulator and interval timer
// Operation
// - Program counter is field register above an 8-bit up-counter; small variant 2-bit field.
// - Field register picks ROM field; counter top 2 bits page, low 6 bits address.
// - Sequential steps increment only the low eight bits, field untouched.
// - LIFO return stack: three 11-bit entries large, one 10-bit entry small.
// - Call or accepted interrupt pushes the current program counter.
// - Program memory is 8-bit words in fields of four 64-word pages.
// - Data RAM addressed by row pointer and 4-bit column pointer.
// - Rows: six with 3 bits, four with 2 bits, two with 1 bit.
// - ALU result goes to the 4-bit accumulator and updates carry.
// - Carry flip-flop set by carry out of a 4-bit addition.
// - Large variant: RAM flag word, bits set, cleared, tested, pointer kept.
// - Large variant: six RAM working registers exchange with column pointer and accumulator.
// - Large variant timer: 6-bit polynomial prescaler plus 6-bit binary counter.
// - Timer-set loads six immediate bits; counting starts after that cycle.
// - Six-bit load value selects one of 64 intervals.
// - Small variants: pseudo-interrupt only and one-entry stack.
`timescale 1ns/1ps
`default_nettype none
`include "mcs_consts.svh"
module mcs_core
  import mcs_pkg::*;
#(
  parameter int FIELD_W = 3,
  parameter int ROW_W = 3,
  parameter int ROWS = 6,
  parameter int STACK_DEPTH = 3
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Operation stream from the instruction sequencer
  input wire mcs_cmd_t i_cmd,
  // Program and data state
  output logic [FIELD_W+7:0] o_pc,
  output logic [`MCS_DATA_W-1:0] o_acc,
  output logic o_carry,
  output logic [ROW_W-1:0] o_row_pointer,
  output logic [`MCS_COL_W-1:0] o_column_pointer,
  output logic [`MCS_DATA_W-1:0] o_ram_rdata,
  output logic [`MCS_LVL_W-1:0] o_stack_level,
  // Test results
  output logic o_skip,
  output logic o_timer_expired
);
  localparam int PC_W = FIELD_W + `MCS_LOW_W;
  localparam int AW = ROW_W + `MCS_COL_W;
  localparam bit LARGE = (FIELD_W == 3);
  localparam logic [ROW_W-1:0] ROW_LAST = ROW_W'(ROWS - 1);
  localparam logic [`MCS_LVL_W-1:0] LVL_MAX = `MCS_LVL_W'(STACK_DEPTH);

  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [PC_W-1:0] stk_r [STACK_DEPTH];
  logic [`MCS_LVL_W-1:0] lvl_r;
  logic [`MCS_DATA_W-1:0] acc_r, acc_nxt;
  logic carry_r, carry_nxt;
  logic [ROW_W-1:0] row_r, row_nxt;
  logic [`MCS_COL_W-1:0] col_r, col_nxt;
  logic [`MCS_DATA_W-1:0] mem [ROWS*16];
  logic [`MCS_DATA_W-1:0] rdata_r;
  logic skip_r, skip_nxt;
  logic [`MCS_TMR_W-1:0] lfsr_r, tcnt_r;
  logic trun_r, texp_r;

  // Field, page and page address views of the counter
  wire [FIELD_W-1:0] rom_field = pc_r[PC_W-1:`MCS_LOW_W];
  wire [`MCS_PAGE_W-1:0] rom_page = pc_r[7:6];
  wire [`MCS_ADDR_W-1:0] rom_addr = pc_r[5:0];
  wire [PC_W-1:0] pc_step = {rom_field, {rom_page, rom_addr} + 8'h01};
  wire [PC_W-1:0] int_vec = {{FIELD_W{1'b0}}, `MCS_INT_VEC_LOW};

  // Pseudo-interrupt parts poll in software, so no vectoring there
  wire int_ok = LARGE && (i_cmd.op == OP_INT);
  wire do_push = (i_cmd.op == OP_CALL) || int_ok;
  wire do_pop = (i_cmd.op == OP_RET) && (lvl_r != '0);

  // RAM addressing; rows beyond the fitted count read zero
  wire [AW-1:0] dp_idx = {row_r, col_r};
  // One bit wider, as a row count of 2**ROW_W would wrap to zero
  wire dp_ok = ({1'b0, row_r} < (ROW_W+1)'(ROWS));
  wire [AW-1:0] flag_idx = {ROW_LAST, `MCS_FLAG_COL};
  wire [AW-1:0] wreg_idx = {ROW_LAST, 1'b0, i_cmd.wsel};
  wire wreg_ok = LARGE && (i_cmd.wsel < `MCS_WREG_COUNT);
  wire [`MCS_DATA_W-1:0] ram_rd = dp_ok ? mem[dp_idx] : '0;
  wire [`MCS_DATA_W-1:0] flag_rd = LARGE ? mem[flag_idx] : '0;
  wire [`MCS_DATA_W-1:0] wreg_rd = wreg_ok ? mem[wreg_idx] : '0;
  wire [`MCS_DATA_W-1:0] bit_mask = `MCS_DATA_W'(1) << i_cmd.bsel;

  // One RAM write per cycle; flag and working words stand in the last row
  wire op_flag = LARGE && (i_cmd.op == OP_FSET || i_cmd.op == OP_FCLR);
  wire op_wreg = wreg_ok && (i_cmd.op == OP_WRA || i_cmd.op == OP_XWA
                 || i_cmd.op == OP_XWD);
  wire op_sta = (i_cmd.op == OP_STA) && dp_ok;
  wire wr_en = op_flag || op_wreg || op_sta;
  wire [AW-1:0] wr_idx = op_flag ? flag_idx : (op_wreg ? wreg_idx : dp_idx);
  wire [`MCS_DATA_W-1:0] flag_wr = (i_cmd.op == OP_FSET) ?
    (flag_rd | bit_mask) : (flag_rd & ~bit_mask);
  wire [`MCS_DATA_W-1:0] wr_data = op_flag ? flag_wr :
    ((i_cmd.op == OP_XWD) ? col_r : acc_r);

  // Adder with carry out of the 4-bit result
  wire cin = (i_cmd.op == OP_ADC) && carry_r;
  wire [`MCS_DATA_W:0] sum = {1'b0, acc_r} + {1'b0, ram_rd}
    + {`MCS_DATA_W'(0), cin};

  // Timer tick once per full prescaler sequence of 63 states
  wire t_tick = trun_r && (lfsr_r == `MCS_LFSR_END);
  wire t_set = LARGE && (i_cmd.op == OP_TSET);
  wire t_done = t_tick && (tcnt_r == '0);
  wire t_clr = (i_cmd.op == OP_TTST);
  wire lfsr_fb = lfsr_r[5] ^ lfsr_r[4];

  always_comb
  begin
    pc_nxt = pc_r;
    case (i_cmd.op)
      OP_STEP: pc_nxt = pc_step;
      OP_JUMP, OP_CALL: pc_nxt = i_cmd.imm[PC_W-1:0];
      OP_INT: pc_nxt = int_ok ? int_vec : pc_r;
      OP_RET: pc_nxt = do_pop ? stk_r[0] : pc_r;
      default: pc_nxt = pc_r;
    endcase
  end

  always_comb
  begin
    acc_nxt = acc_r;
    carry_nxt = carry_r;
    row_nxt = row_r;
    col_nxt = col_r;
    skip_nxt = 1'b0;
    case (i_cmd.op)
      OP_ADD, OP_ADC:
      begin
        acc_nxt = sum[`MCS_DATA_W-1:0];
        carry_nxt = sum[`MCS_DATA_W];
      end
      OP_AND:
      begin
        acc_nxt = acc_r & ram_rd;
        carry_nxt = 1'b0;
      end
      OP_OR:
      begin
        acc_nxt = acc_r | ram_rd;
        carry_nxt = 1'b0;
      end
      OP_XOR:
      begin
        acc_nxt = acc_r ^ ram_rd;
        carry_nxt = 1'b0;
      end
      OP_LDA: acc_nxt = ram_rd;
      OP_LDP:
      begin
        row_nxt = i_cmd.imm[ROW_W+3:4];
        col_nxt = i_cmd.imm[3:0];
      end
      OP_FTST: skip_nxt = ((flag_rd & bit_mask) != '0) == i_cmd.imm[0];
      OP_XWA: acc_nxt = wreg_ok ? wreg_rd : acc_r;
      OP_XWD: col_nxt = wreg_ok ? wreg_rd : col_r;
      OP_TTST: skip_nxt = texp_r;
      default: skip_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pc_r <= '0;
      acc_r <= '0;
      carry_r <= 1'b0;
      row_r <= '0;
      col_r <= '0;
      skip_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      pc_r <= pc_nxt;
      acc_r <= acc_nxt;
      carry_r <= carry_nxt;
      row_r <= row_nxt;
      col_r <= col_nxt;
      skip_r <= skip_nxt;
      rdata_r <= ram_rd;
    end
  end

  // Data RAM has no reset, like the array it stands for
  always_ff @(posedge i_sys_clk)
  begin
    if (wr_en)
      mem[wr_idx] <= wr_data;
  end

  // Push shifts down; a push into a full stack drops the oldest entry
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      lvl_r <= '0;
      for (int i = 0; i < STACK_DEPTH; i++)
        stk_r[i] <= '0;
    end
    else if (do_push)
    begin
      stk_r[0] <= pc_r;
      for (int i = 1; i < STACK_DEPTH; i++)
        stk_r[i] <= stk_r[i-1];
      lvl_r <= (lvl_r == LVL_MAX) ? lvl_r : lvl_r + 1'b1;
    end
    else if (do_pop)
    begin
      for (int i = 0; i < STACK_DEPTH - 1; i++)
        stk_r[i] <= stk_r[i+1];
      stk_r[STACK_DEPTH-1] <= '0;
      lvl_r <= lvl_r - 1'b1;
    end
  end

  // Interval of value N is (N+1) prescaler sequences; expiry set beats clear
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      lfsr_r <= `MCS_LFSR_SEED;
      tcnt_r <= '0;
      trun_r <= 1'b0;
      texp_r <= 1'b0;
    end
    else if (t_set)
    begin
      lfsr_r <= `MCS_LFSR_SEED;
      tcnt_r <= i_cmd.imm[`MCS_TMR_W-1:0];
      trun_r <= 1'b1;
      texp_r <= t_clr ? 1'b0 : texp_r;
    end
    else
    begin
      lfsr_r <= trun_r ? {lfsr_r[4:0], lfsr_fb} : lfsr_r;
      tcnt_r <= t_tick ? tcnt_r - 1'b1 : tcnt_r;
      trun_r <= trun_r && !t_done;
      texp_r <= t_done || (texp_r && !t_clr);
    end
  end

  assign o_pc = pc_r;
  assign o_acc = acc_r;
  assign o_carry = carry_r;
  assign o_row_pointer = row_r;
  assign o_column_pointer = col_r;
  assign o_ram_rdata = rdata_r;
  assign o_stack_level = lvl_r;
  assign o_skip = skip_r;
  assign o_timer_expired = texp_r;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  step_keeps_field_a: assert property (
    i_cmd.op == OP_STEP |=> pc_r[PC_W-1:8] == $past(pc_r[PC_W-1:8])
      && pc_r[7:0] == $past(pc_r[7:0]) + 8'h01)
    else $error("step changed field or missed increment");
  call_push_a: assert property (
    i_cmd.op == OP_CALL |=> stk_r[0] == $past(pc_r)
      && pc_r == $past(i_cmd.imm[PC_W-1:0]))
    else $error("call did not push current counter");
  ret_restore_a: assert property (
    (i_cmd.op == OP_CALL ##1 i_cmd.op == OP_RET) |=> pc_r == $past(pc_r, 2))
    else $error("return did not restore pushed counter");
  stack_depth_a: assert property (lvl_r <= LVL_MAX)
    else $error("stack level above depth");
  add_carry_a: assert property (
    i_cmd.op == OP_ADD |=> {carry_r, acc_r} == $past(acc_r) + $past(ram_rd))
    else $error("add result or carry wrong");
  flag_set_a: assert property (
    LARGE && i_cmd.op == OP_FSET ##1 i_cmd.op == OP_FTST && i_cmd.imm[0]
      && i_cmd.bsel == $past(i_cmd.bsel) && $stable(row_r) |=> skip_r)
    else $error("flag bit not seen set");
  timer_load_a: assert property (
    t_set |=> tcnt_r == $past(i_cmd.imm[5:0]) && trun_r
      && lfsr_r == `MCS_LFSR_SEED)
    else $error("timer set did not load counter");
  timer_zero_a: assert property (
    t_set && !texp_r && i_cmd.imm[5:0] == 6'h00 ##1 (!t_set)[*8] |-> trun_r && !texp_r)
    else $error("timer expired too early");
  timer_expire_a: assert property (
    t_done && !t_set |=> texp_r && !trun_r)
    else $error("expiry flag not raised");

  cov_call_ret: cover property (i_cmd.op == OP_CALL ##[1:4] i_cmd.op == OP_RET);
  cov_page_cross: cover property (i_cmd.op == OP_STEP && pc_r[5:0] == 6'h3f);
  cov_expire: cover property ($rose(texp_r));
  cov_carry: cover property (i_cmd.op == OP_ADD && sum[`MCS_DATA_W]);
endmodule : mcs_core
`default_nettype wire

// ### src/mcs_consts.svh
// Constants for the controller core sequencer, storage and timer
`ifndef MCS_CONSTS_SVH
`define MCS_CONSTS_SVH
`define MCS_LOW_W 8
`define MCS_PAGE_W 2
`define MCS_ADDR_W 6
`define MCS_COL_W 4
`define MCS_DATA_W 4
`define MCS_FLAG_COL 4'hf
`define MCS_WREG_COUNT 3'h6
`define MCS_INT_VEC_LOW 8'h10
`define MCS_TMR_W 6
`define MCS_LFSR_SEED 6'h3f
// State just before the seed returns, so every tick is a full 63-state sequence
`define MCS_LFSR_END 6'h1f
`define MCS_LVL_W 2
`endif

// ### src/mcs_pkg.sv
// Types for the controller core sequencer, storage and timer
package mcs_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_STEP, OP_JUMP, OP_CALL, OP_INT, OP_RET,
    OP_ADD, OP_ADC, OP_AND, OP_OR, OP_XOR, OP_LDA, OP_STA, OP_LDP,
    OP_FSET, OP_FCLR, OP_FTST, OP_WRA, OP_XWA, OP_XWD, OP_TSET, OP_TTST
  } mcs_op_t;
  typedef struct packed {
    mcs_op_t op;
    logic [10:0] imm;
    logic [1:0] bsel;
    logic [2:0] wsel;
  } mcs_cmd_t;
endpackage : mcs_pkg

// ### test/test_mcs_core.sv
// Self-checking bench for the core sequencer, storage and timer
`timescale 1ns/1ps
`default_nettype none
module test_mcs_core
  import mcs_pkg::*;
;
  logic i_sys_clk;
  logic i_reset_n;
  mcs_cmd_t cmd;
  logic [10:0] pc;
  logic [3:0] acc, col, rdata;
  logic carry, skip, texp;
  logic [2:0] row;
  logic [1:0] lvl;
  int err_total = 0;
  int n_checks = 0;

  mcs_core i_mcs_core (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_cmd(cmd), .o_pc(pc), .o_acc(acc),
    .o_carry(carry), .o_row_pointer(row), .o_column_pointer(col), .o_ram_rdata(rdata),
    .o_stack_level(lvl), .o_skip(skip), .o_timer_expired(texp)
  );

  initial
  begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Each operation is held for one edge, then a no-op follows so outputs settle
  task automatic do_op(input mcs_op_t op, input logic [10:0] imm = 11'h000,
                       input logic [1:0] bsel = 2'h0);
    @(posedge i_sys_clk);
    cmd <= '{op: op, imm: imm, bsel: bsel, wsel: 3'h0};
    @(posedge i_sys_clk);
    cmd <= '{op: OP_NOP, imm: 11'h000, bsel: 2'h0, wsel: 3'h0};
    #1;
  endtask : do_op

  // Two operations on consecutive edges, then a no-op
  task automatic do_pair(input mcs_op_t op_a, input logic [10:0] imm_a, input mcs_op_t op_b,
                         input logic [10:0] imm_b, input logic [1:0] bsel);
    @(posedge i_sys_clk);
    cmd <= '{op: op_a, imm: imm_a, bsel: bsel, wsel: 3'h0};
    @(posedge i_sys_clk);
    cmd <= '{op: op_b, imm: imm_b, bsel: bsel, wsel: 3'h0};
    @(posedge i_sys_clk);
    cmd <= '{op: OP_NOP, imm: 11'h000, bsel: 2'h0, wsel: 3'h0};
    #1;
  endtask : do_pair

  task automatic t_reset();
    chk(pc, 11'h000, "pc reset");
    chk({acc, carry, lvl, skip, texp}, 11'h000, "state reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_pc();
    do_op(OP_JUMP, 11'h5bf);
    do_op(OP_STEP);
    chk(pc, 11'h5c0, "page carry");
    do_op(OP_JUMP, 11'h5ff);
    do_op(OP_STEP);
    chk(pc, 11'h500, "field kept on wrap");
    chk(pc[10:8], 11'h005, "field bits");
    $display("test pc done");
  endtask : t_pc

  task automatic t_stack();
    do_op(OP_JUMP, 11'h123);
    do_op(OP_CALL, 11'h234);
    chk(pc, 11'h234, "call target");
    do_op(OP_CALL, 11'h345);
    do_op(OP_INT);
    chk(pc, 11'h010, "interrupt vector");
    do_op(OP_CALL, 11'h456);
    chk(lvl, 11'h003, "three levels");
    do_op(OP_RET);
    chk(pc, 11'h010, "pop newest");
    do_op(OP_RET);
    chk(pc, 11'h345, "pop second");
    do_op(OP_RET);
    chk(pc, 11'h234, "pop third");
    chk(lvl, 11'h000, "stack empty");
    do_op(OP_RET);
    chk(pc, 11'h234, "empty pop ignored");
    do_pair(OP_CALL, 11'h3a5, OP_RET, 11'h000, 2'h0);
    chk(pc, 11'h234, "back to back return");
    chk(lvl, 11'h000, "stack empty again");
    $display("test stack done");
  endtask : t_stack

  task automatic t_alu();
    do_op(OP_LDP, 11'h009);
    do_op(OP_XWD);
    do_op(OP_XWA);
    chk(acc, 11'h009, "working register exchange");
    do_op(OP_LDP, 11'h053);
    chk({row, col}, 11'h053, "row and column");
    do_op(OP_STA);
    do_op(OP_NOP);
    chk(rdata, 11'h009, "ram word");
    do_op(OP_ADD);
    chk({carry, acc}, 11'h012, "add with carry out");
    do_op(OP_ADC);
    chk({carry, acc}, 11'h00c, "add carry in");
    do_op(OP_AND);
    chk({carry, acc}, 11'h008, "logic result");
    do_op(OP_OR);
    chk({carry, acc}, 11'h009, "or result");
    do_op(OP_WRA);
    do_op(OP_XOR);
    chk({carry, acc}, 11'h000, "xor result");
    do_op(OP_XWA);
    chk(acc, 11'h009, "working register written");
    do_op(OP_XWA);
    chk(acc, 11'h000, "working register swapped back");
    do_op(OP_LDA);
    chk(acc, 11'h009, "load from pointer");
    $display("test alu done");
  endtask : t_alu

  task automatic t_flag();
    do_op(OP_FSET, 11'h000, 2'h2);
    do_op(OP_FTST, 11'h001, 2'h2);
    chk(skip, 11'h001, "flag set tested");
    do_op(OP_NOP);
    chk(skip, 11'h000, "skip one cycle");
    do_op(OP_FCLR, 11'h000, 2'h2);
    do_op(OP_FTST, 11'h000, 2'h2);
    chk(skip, 11'h001, "flag clear tested");
    do_pair(OP_FSET, 11'h000, OP_FTST, 11'h001, 2'h1);
    chk(skip, 11'h001, "flag set then tested");
    chk({row, col}, 11'h053, "pointer kept by flag ops");
    $display("test flag done");
  endtask : t_flag

  task automatic t_timer();
    int n;
    n = 0;
    do_op(OP_TSET, 11'h000);
    // Value N gives N+1 prescaler sequences of 63 cycles each
    while (texp !== 1'b1 && n < 400)
    begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk(11'(n), 11'h03f, "shortest interval");
    do_op(OP_TTST);
    chk({skip, texp}, 11'h002, "first expiry clears");
    n = 0;
    do_op(OP_TSET, 11'h001);
    while (texp !== 1'b1 && n < 400)
    begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk(11'(n), 11'h07e, "timer interval");
    do_op(OP_TTST);
    chk({skip, texp}, 11'h002, "expiry test clears");
    $display("test timer done");
  endtask : t_timer

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    i_reset_n = 1'b0;
    cmd = '{op: OP_NOP, imm: 11'h000, bsel: 2'h0, wsel: 3'h0};
    repeat (10) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    #1;
    t_reset();
    t_pc();
    t_stack();
    t_alu();
    t_flag();
    t_timer();
    tally_and_finish();
  end

  // Whole run is well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge i_sys_clk);
    err_total++;
    tally_and_finish();
  end
endmodule : test_mcs_core
`default_nettype wire
